// ===== design/fsph_host.sv
// host controller driving the converter serial port from its own clock
`timescale 1ns/1ps
module fsph_host (
    input  wire logic                  CORE_CLK_I,
    input  wire logic                  RST_N_I,
    input  wire logic                  CE_I,
    input  wire logic                  CMD_VALID_I,
    input  wire fsph_pkg::fsph_cmd_type CMD_KIND_I,
    input  wire logic [23:0]           CMD_WDATA_I,
    output logic                       CMD_READY_O,
    output logic                       CMD_REFUSED_O,
    input  wire logic                  OPT_BYTE_MODE_I,
    input  wire logic                  OPT_LSB_FIRST_I,
    input  wire logic                  OPT_TIE_SELECT_I,
    input  wire logic                  OPT_TX_FROM_RX_I,
    output logic                       RD_VALID_O,
    output logic [23:0]                RD_DATA_O,
    input  wire logic                  RD_READY_I,
    output logic                       SCLK_O,
    output logic                       RECEIVE_FRAME_N_O,
    output logic                       TRANSMIT_FRAME_N_O,
    output logic                       REGISTER_SELECT_O,
    input  wire logic                  SDATA_I,
    output logic                       SDATA_O,
    output logic                       SDATA_OE_O,
    input  wire logic                  DATA_READY_N_I,
    output logic                       BUSY_O
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT_RDY, ST_LOW, ST_HIGH, ST_GAP, ST_DONE
    } fsph_state_type;

    fsph_state_type          state;
    fsph_state_type          next_state;
    fsph_pkg::fsph_cmd_type  kind;
    logic [fsph_pkg::PH_W-1:0]   ph_cnt;
    logic [fsph_pkg::BITS_W-1:0] bit_cnt;
    logic [fsph_pkg::BITS_W-1:0] next_bits;
    logic [23:0]             shreg;
    logic [23:0]             wdata_rev;
    logic [23:0]             rdata_rev;
    logic [23:0]             word_tx;
    logic [fsph_pkg::SYNC_W-1:0] sync_in;
    logic                    rdy_n_s;
    logic                    sdata_s;
    logic                    byte_q;
    logic                    lsb_q;
    logic                    tie_q;
    logic                    inv_q;
    logic                    accept;
    logic                    refuse;
    logic                    legal;
    logic                    is_read;
    logic                    is_write;
    logic                    ph_end;
    logic                    push;
    logic                    fifo_ready;
    logic                    next_rx_low;
    logic                    next_tx_low;
    logic                    next_tfs;
    logic                    cmd_read;
    logic                    cmd_sel;

    fsph_sync #(
        .WIDTH   (fsph_pkg::SYNC_W),
        .RST_VAL (fsph_pkg::SYNC_RST)
    ) u_sync (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RST_N_I),
        .ce_i    (CE_I),
        .async_i ({DATA_READY_N_I, SDATA_I}),
        .sync_o  (sync_in)
    );
    assign rdy_n_s = sync_in[fsph_pkg::SYNC_RDY];
    assign sdata_s = sync_in[fsph_pkg::SYNC_DAT];

    for (genvar i = 0; i < fsph_pkg::WORD_W; i++) begin : g_rev
        localparam int J = (i / fsph_pkg::BYTE_W) * fsph_pkg::BYTE_W
                         + fsph_pkg::BYTE_W - 1 - (i % fsph_pkg::BYTE_W);
        assign wdata_rev[i] = CMD_WDATA_I[J];
        assign rdata_rev[i] = shreg[J];
    end
    // msb of the word goes first, unless lsb first is set, which reverses the bits inside each byte
    assign word_tx = OPT_LSB_FIRST_I ? wdata_rev : CMD_WDATA_I;

    assign legal    = (CMD_KIND_I inside {fsph_pkg::CMD_RD_OUT,
                       fsph_pkg::CMD_RD_CTL, fsph_pkg::CMD_RD_CAL,
                       fsph_pkg::CMD_WR_CTL, fsph_pkg::CMD_WR_CAL});
    assign cmd_read = (CMD_KIND_I inside {fsph_pkg::CMD_RD_OUT,
                       fsph_pkg::CMD_RD_CTL, fsph_pkg::CMD_RD_CAL});
    assign cmd_sel  = (CMD_KIND_I inside {fsph_pkg::CMD_RD_CTL,
                       fsph_pkg::CMD_WR_CTL}) ? fsph_pkg::SEL_CTL
                                              : fsph_pkg::SEL_DATA;
    assign accept   = CE_I && CMD_VALID_I && CMD_READY_O;
    // no control reads in tied wiring
    assign refuse   = !legal
                   || (OPT_TIE_SELECT_I && CMD_KIND_I == fsph_pkg::CMD_RD_CTL);
    assign is_read  = (kind inside {fsph_pkg::CMD_RD_OUT,
                       fsph_pkg::CMD_RD_CTL, fsph_pkg::CMD_RD_CAL});
    assign is_write = !is_read;
    assign ph_end   = (ph_cnt == fsph_pkg::PH_LAST);
    assign next_bits = bit_cnt + fsph_pkg::BITS_ONE;
    assign push     = (state == ST_HIGH) && ph_end && is_read
                   && (next_bits == fsph_pkg::WORD_BITS);

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (accept && !refuse) begin
                    // only output reads wait on data ready
                    next_state = (CMD_KIND_I == fsph_pkg::CMD_RD_OUT)
                               ? ST_WAIT_RDY : ST_LOW;
                end
            end
            ST_WAIT_RDY: begin
                // frame only when data ready is low
                if (!rdy_n_s) begin
                    next_state = ST_LOW;
                end
            end
            ST_LOW: begin
                if (ph_end) begin
                    next_state = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (ph_end) begin
                    if (next_bits == fsph_pkg::WORD_BITS) begin
                        next_state = ST_DONE;
                    end else if (byte_q
                                 && bit_cnt[2:0] == fsph_pkg::BYTE_LAST) begin
                        next_state = ST_GAP;
                    end else begin
                        next_state = ST_LOW;
                    end
                end
            end
            ST_GAP: begin
                if (ph_end) begin
                    // data ready checked before each byte of an output read
                    next_state = (kind == fsph_pkg::CMD_RD_OUT)
                               ? ST_WAIT_RDY : ST_LOW;
                end
            end
            ST_DONE: begin
                // let data ready settle before next command
                if (ph_end) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state <= ST_IDLE;
        end else if (CE_I) begin
            state <= next_state;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ph_cnt  <= fsph_pkg::PH_ZERO;
            bit_cnt <= fsph_pkg::BITS_ZERO;
        end else if (CE_I) begin
            ph_cnt <= (next_state != state) ? fsph_pkg::PH_ZERO
                                            : ph_cnt + fsph_pkg::PH_ONE;
            if (state == ST_IDLE) begin
                bit_cnt <= fsph_pkg::BITS_ZERO;
            end else if (state == ST_HIGH && ph_end) begin
                bit_cnt <= next_bits;
            end
        end
    end

    // command and options held for the whole transfer
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            kind   <= fsph_pkg::CMD_RD_OUT;
            byte_q <= 1'b0;
            lsb_q  <= 1'b0;
            tie_q  <= 1'b0;
            inv_q  <= 1'b0;
        end else if (CE_I && state == ST_IDLE) begin
            byte_q <= OPT_BYTE_MODE_I;
            lsb_q  <= OPT_LSB_FIRST_I;
            tie_q  <= OPT_TIE_SELECT_I;
            inv_q  <= OPT_TX_FROM_RX_I;
            if (accept && !refuse) begin
                kind <= CMD_KIND_I;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CMD_READY_O   <= 1'b0;
            CMD_REFUSED_O <= 1'b0;
            BUSY_O        <= 1'b0;
        end else if (CE_I) begin
            CMD_READY_O   <= !accept && next_state == ST_IDLE && fifo_ready;
            CMD_REFUSED_O <= accept && refuse;
            BUSY_O        <= (next_state != ST_IDLE);
        end
    end

    // shift register: serial in and out
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            shreg   <= fsph_pkg::WORD_ZERO;
            SDATA_O <= 1'b0;
        end else if (CE_I) begin
            if (accept && !refuse) begin
                shreg   <= cmd_read ? fsph_pkg::WORD_ZERO : word_tx;
                SDATA_O <= cmd_read ? 1'b0 : word_tx[23];
            end else if (state == ST_LOW && ph_end && is_read) begin
                // first bit in is the msb
                shreg <= {shreg[22:0], sdata_s};
            end else if (state == ST_HIGH && ph_end && is_write) begin
                // data changes only on the falling edge
                shreg   <= {shreg[22:0], 1'b0};
                SDATA_O <= shreg[22];
            end
        end
    end

    always_comb begin
        next_rx_low = is_read && (next_state inside {ST_LOW, ST_HIGH});
        next_tx_low = is_write && (next_state inside {ST_LOW, ST_HIGH});
        if (next_state == ST_IDLE || state == ST_IDLE) begin
            next_rx_low = (state == ST_IDLE) && cmd_read && accept
                       && !refuse && CMD_KIND_I != fsph_pkg::CMD_RD_OUT;
            next_tx_low = (state == ST_IDLE) && !cmd_read && accept
                       && !refuse;
        end
        // transmit frame as inverted receive frame
        next_tfs = (state == ST_IDLE ? OPT_TX_FROM_RX_I : inv_q)
                 ? next_rx_low : !next_tx_low;
    end

    // receive frame comes straight from the sequencer
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RECEIVE_FRAME_N_O  <= 1'b1;
            TRANSMIT_FRAME_N_O <= 1'b1;
            REGISTER_SELECT_O  <= fsph_pkg::SEL_DATA;
            SCLK_O             <= 1'b0;
            SDATA_OE_O         <= 1'b0;
        end else if (CE_I) begin
            RECEIVE_FRAME_N_O  <= !next_rx_low;
            TRANSMIT_FRAME_N_O <= next_tfs;
            SCLK_O             <= (next_state == ST_HIGH);
            SDATA_OE_O         <= next_tx_low
                               || (is_write && next_state == ST_GAP);
            // tied wiring follows the transmit frame
            if ((state == ST_IDLE) ? OPT_TIE_SELECT_I : tie_q) begin
                REGISTER_SELECT_O <= next_tfs;
            end else if (accept && !refuse) begin
                // select set on accept, with the frame edge, or before it for output reads
                // select held for the whole transfer
                REGISTER_SELECT_O <= cmd_sel;
            end
        end
    end

    fsph_fifo #(
        .WIDTH (fsph_pkg::WORD_W),
        .DEPTH (fsph_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CORE_CLK_I),
        .rst_n_i     (RST_N_I),
        .ce_i        (CE_I),
        .in_valid_i  (push),
        .in_data_i   (lsb_q ? rdata_rev : shreg),
        .in_ready_o  (fifo_ready),
        .out_valid_o (RD_VALID_O),
        .out_data_o  (RD_DATA_O),
        .out_ready_i (RD_READY_I)
    );

    a_tie_write_ctl: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $past(tie_q) && state != ST_IDLE && !TRANSMIT_FRAME_N_O
        |-> REGISTER_SELECT_O == fsph_pkg::SEL_CTL)
        else $error("tied select not low during write frame");

    a_tie_ctl_refused: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        accept && OPT_TIE_SELECT_I && CMD_KIND_I == fsph_pkg::CMD_RD_CTL
        |=> CMD_REFUSED_O && state == ST_IDLE && RECEIVE_FRAME_N_O)
        else $error("control read not refused in tied wiring");

    a_tx_inverse_rx: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $past(inv_q) && state != ST_IDLE && $past(state) != ST_IDLE
        |-> TRANSMIT_FRAME_N_O != RECEIVE_FRAME_N_O)
        else $error("transmit frame not inverse of receive frame");

    a_rx_only_reads: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $fell(RECEIVE_FRAME_N_O) |-> is_read && !SDATA_OE_O)
        else $error("receive frame low outside a read");

    a_ready_before_read: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $fell(RECEIVE_FRAME_N_O) && kind == fsph_pkg::CMD_RD_OUT
        |-> !$past(rdy_n_s))
        else $error("output read framed while data ready high");

    a_ctl_no_wait: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        accept && !refuse && CMD_KIND_I inside {fsph_pkg::CMD_RD_CTL,
                                                fsph_pkg::CMD_RD_CAL}
        |-> ##[1:2] !RECEIVE_FRAME_N_O)
        else $error("register read waited for data ready");

    a_ctl_read_select: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !RECEIVE_FRAME_N_O && kind == fsph_pkg::CMD_RD_CTL
        |-> REGISTER_SELECT_O == fsph_pkg::SEL_CTL)
        else $error("control read without select low");

    a_wdata_stable: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        SCLK_O && $past(SCLK_O) |-> $stable(SDATA_O))
        else $error("write data moved during clock high");

    a_select_stable: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        BUSY_O && $past(BUSY_O)
        |-> (tie_q ? REGISTER_SELECT_O == TRANSMIT_FRAME_N_O
                   : $stable(REGISTER_SELECT_O)))
        else $error("select changed inside a transfer");

    a_byte_gap: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        state == ST_GAP |-> byte_q && bit_cnt[2:0] == fsph_pkg::BYTE_FIRST
                         && SCLK_O == 1'b0)
        else $error("byte gap off a byte boundary");

    a_word_length: assert property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $rose(state == ST_DONE) |-> bit_cnt == fsph_pkg::WORD_BITS)
        else $error("transfer did not run 24 clocks");

    c_output_read: cover property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        push && kind == fsph_pkg::CMD_RD_OUT);
    c_byte_write: cover property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        state == ST_GAP && is_write);
    c_fifo_full: cover property (
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !fifo_ready && RD_VALID_O);
endmodule

// ===== common/fsph_pkg.sv
// constants and types of the framed serial port host
package fsph_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_HALF_NS  = 80;
    localparam int HALF_CYC      =
        (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PH_W          = 4;
    localparam int WORD_W        = 24;
    localparam int BYTE_W        = 8;
    localparam int BITS_W        = 5;
    localparam int FIFO_DEPTH    = 8;
    localparam int SYNC_W        = 2;

    localparam logic [PH_W-1:0]   PH_ZERO    = 4'h0;
    localparam logic [PH_W-1:0]   PH_ONE     = 4'h1;
    localparam logic [PH_W-1:0]   PH_LAST    = PH_W'(HALF_CYC - 1);
    localparam logic [BITS_W-1:0] BITS_ZERO  = 5'h00;
    localparam logic [BITS_W-1:0] BITS_ONE   = 5'h01;
    localparam logic [BITS_W-1:0] WORD_BITS  = 5'h18;
    localparam logic [2:0]        BYTE_LAST  = 3'h7;
    localparam logic [2:0]        BYTE_FIRST = 3'h0;
    localparam logic [WORD_W-1:0] WORD_ZERO  = 24'h000000;

    // select level: low reaches the control register
    localparam logic SEL_CTL   = 1'b0;
    localparam logic SEL_DATA  = 1'b1;
    // sync reset: bit 1 data ready (idle high), bit 0 serial data
    localparam logic [SYNC_W-1:0] SYNC_RST = 2'h2;
    localparam int   SYNC_RDY  = 1;
    localparam int   SYNC_DAT  = 0;

    typedef enum logic [2:0] {
        CMD_RD_OUT = 3'h0,
        CMD_RD_CTL = 3'h1,
        CMD_RD_CAL = 3'h2,
        CMD_WR_CTL = 3'h3,
        CMD_WR_CAL = 3'h4
    } fsph_cmd_type;
endpackage

// ===== design/fsph_sync.sv
// three-stage input synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
module fsph_sync #(
    parameter int              WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
            sync_o <= RST_VAL;
        end else if (ce_i) begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
            sync_o <= (stage2 & ~(stage2 ^ stage3))
                    | (sync_o & (stage2 ^ stage3));
        end
    end
endmodule

// ===== design/fsph_fifo.sv
// flip-flop fifo with registered output stage
`timescale 1ns/1ps
module fsph_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW    = $clog2(DEPTH);
    localparam int CNT_W = AW + 1;
    localparam logic [AW-1:0]    PTR_ONE = AW'(1);
    localparam logic [AW-1:0]    PTR_MAX = AW'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [CNT_W-1:0] count;
    logic             push;
    logic             pop;

    assign in_ready_o = (count < CNT_MAX);
    assign push = in_valid_i && in_ready_o;
    assign pop  = (count != '0) && (!out_valid_o || out_ready_i);

    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            mem[wptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else if (ce_i) begin
            if (push) begin
                wptr <= (wptr == PTR_MAX) ? '0 : wptr + PTR_ONE;
            end
            if (pop) begin
                rptr <= (rptr == PTR_MAX) ? '0 : rptr + PTR_ONE;
            end
            if (push && !pop) begin
                count <= count + CNT_ONE;
            end else if (pop && !push) begin
                count <= count - CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else if (ce_i) begin
            if (pop) begin
                out_valid_o <= 1'b1;
                out_data_o  <= mem[rptr];
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end
endmodule

// ===== testbench/fsph_dev_model.sv
// behavioural converter serial port facing the host controller
`timescale 1ns/1ps
module fsph_dev_model (
    input  wire logic sclk_i,
    input  wire logic receive_frame_n_i,
    input  wire logic transmit_frame_n_i,
    input  wire logic register_select_i,
    input  wire logic sdata_i,
    output logic      sdata_o,
    output logic      data_ready_n_o
);
    logic [23:0] ctl_reg  = 24'h000000;
    logic [23:0] cal_reg  = 24'h000000;
    logic [23:0] out_reg  = 24'h000000;
    logic [23:0] rd_sr    = 24'h000000;
    logic [23:0] wr_sr    = 24'h000000;
    int          rd_cnt   = 0;
    int          wr_cnt   = 0;
    logic        from_out = 1'b0;
    logic        rd_act   = 1'b0;
    initial data_ready_n_o = 1'b1;
    // released line shows the inverse of the next bit
    assign sdata_o = receive_frame_n_i ? ~rd_sr[23] : rd_sr[23];
    task automatic new_sample(input logic [23:0] w);
        out_reg = w;
        data_ready_n_o = 1'b0;
    endtask
    // source picked once per word, after select settles
    always @(negedge receive_frame_n_i) begin
        #1;
        rd_act = 1'b1;
        if (rd_cnt == 0) begin
            from_out = register_select_i && !data_ready_n_o;
            rd_sr = !register_select_i ? ctl_reg
                  : (from_out ? out_reg : cal_reg);
        end
    end
    // frame end seen late, so a clock fall on the same edge still counts
    always @(posedge receive_frame_n_i) begin
        #1;
        rd_act = 1'b0;
    end
    // msb first, next bit on falling clock
    always @(negedge sclk_i) begin
        if (rd_act) begin
            rd_sr = {rd_sr[22:0], ~rd_sr[0]};
            rd_cnt++;
            if (rd_cnt == 24) begin
                rd_cnt = 0;
                if (from_out)
                    data_ready_n_o = 1'b1;
            end
        end
    end
    // 24 bits taken on clock high, msb first
    always @(posedge sclk_i) begin
        if (!transmit_frame_n_i) begin
            wr_sr = {wr_sr[22:0], sdata_i};
            wr_cnt++;
            if (wr_cnt == 24) begin
                wr_cnt = 0;
                if (register_select_i)
                    cal_reg = wr_sr;
                else
                    ctl_reg = wr_sr;
            end
        end
    end
endmodule

// ===== testbench/fsph_host_test.sv
// self-checking bench of the serial port host controller
`timescale 1ns/1ps
module fsph_host_test;
    logic                   clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   cmd_valid = 1'b0;
    fsph_pkg::fsph_cmd_type kind = fsph_pkg::CMD_RD_OUT;
    logic [23:0]            wdata = 24'h000000;
    logic [3:0]             opt = 4'h0;
    logic                   rd_ready = 1'b1;
    logic                   stall = 1'b0;
    logic                   ready, refused, rd_valid, sclk, rfs_n;
    logic                   tfs_n, sel, sdo, sd_oe, busy, dev_sdo, data_ready_n_n;
    logic [23:0]            rd_data, exp_ctl, w, r;
    logic [31:0]            seed = 32'hc104;
    logic [23:0]            expq[$];
    int                     err_total = 0;
    int                     samples_checked = 0;
    wire                    sd_line = sd_oe ? sdo : dev_sdo;
    fsph_host uut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
        .CMD_VALID_I(cmd_valid), .CMD_KIND_I(kind), .CMD_WDATA_I(wdata),
        .CMD_READY_O(ready), .CMD_REFUSED_O(refused),
        .OPT_BYTE_MODE_I(opt[0]), .OPT_LSB_FIRST_I(opt[1]),
        .OPT_TIE_SELECT_I(opt[3]), .OPT_TX_FROM_RX_I(opt[2]),
        .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data), .RD_READY_I(rd_ready),
        .SCLK_O(sclk), .RECEIVE_FRAME_N_O(rfs_n),
        .TRANSMIT_FRAME_N_O(tfs_n), .REGISTER_SELECT_O(sel),
        .SDATA_I(sd_line), .SDATA_O(sdo), .SDATA_OE_O(sd_oe),
        .DATA_READY_N_I(data_ready_n_n), .BUSY_O(busy));
    fsph_dev_model dev (.sclk_i(sclk), .receive_frame_n_i(rfs_n),
        .transmit_frame_n_i(tfs_n), .register_select_i(sel),
        .sdata_i(sd_line), .sdata_o(dev_sdo), .data_ready_n_o(data_ready_n_n));
    function automatic logic [23:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[23:0];
    endfunction
    function automatic logic [23:0] rev(input logic [23:0] v, input logic on);
        logic [23:0] q;
        for (int i = 0; i < 24; i++)
            q[i] = on ? v[(i / 8) * 8 + 7 - i % 8] : v[i];
        return q;
    endfunction
    task automatic check(input logic [23:0] seen, exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic settle(input int cyc);
        repeat (cyc) @(negedge clk);
    endtask
    task automatic issue(input logic [2:0] k, input logic [23:0] d);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 3000) begin
            settle(1);
            n++;
        end
        check(24'(n < 3000), 24'h1, "ready wait");
        cmd_valid = 1'b1;
        kind = fsph_pkg::fsph_cmd_type'(k);
        wdata = d;
        settle(1);
        cmd_valid = 1'b0;
    endtask
    task automatic idle();
        int n;
        n = 0;
        while ((busy !== 1'b0 || ready !== 1'b1) && n < 3000) begin
            settle(1);
            n++;
        end
        check(24'(n < 3000), 24'h1, "idle wait");
    endtask
    always @(posedge clk) begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1)
            check(rd_data, expq.pop_front(), "result");
    end
    always @(negedge clk) begin
        if (stall) begin
            r = rnd();
            rd_ready = r[0];
        end
    end
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #800000;
        err_total++;
        wrap_up();
    end
    initial begin
        settle(2);
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            opt = {1'b0, i[2:0]};
            w = rnd();
            exp_ctl = rev(w, opt[1]);
            issue(3'h3, w);
            idle();
            check(dev.ctl_reg, exp_ctl, "ctl");
            w = rnd();
            issue(3'h4, w);
            idle();
            check(dev.cal_reg, rev(w, opt[1]), "cal");
            expq.push_back(w);
            issue(3'h2, 24'h000000);
            expq.push_back(rev(exp_ctl, opt[1]));
            issue(3'h1, 24'h000000);
            issue(3'h0, 24'h000000);
            settle(40);
            check(24'(rfs_n), 24'h1, "frame");
            w = rnd();
            expq.push_back(rev(w, opt[1]));
            dev.new_sample(w);
            idle();
            check(24'(rfs_n), 24'h1, "end");
            check(24'(tfs_n), 24'(!opt[2]), "tx");
            check(24'(expq.size()), 24'h0, "queue");
        end
        opt = 4'h8;
        issue(3'h1, 24'h000000);
        check(24'(refused), 24'h1, "refuse");
        issue(3'h7, 24'h000000);
        check(24'(refused), 24'h1, "illegal");
        w = rnd();
        issue(3'h4, w);
        idle();
        check(dev.ctl_reg, w, "tied");
        opt = 4'h0;
        rd_ready = 1'b0;
        repeat (9) begin
            expq.push_back(dev.cal_reg);
            issue(3'h2, 24'h000000);
        end
        settle(500);
        check(24'(ready), 24'h0, "full");
        stall = 1'b1;
        settle(100);
        stall = 1'b0;
        rd_ready = 1'b1;
        settle(20);
        check(24'(expq.size()), 24'h0, "drain");
        check(24'(rd_valid), 24'h0, "empty");
        wrap_up();
    end
endmodule
